// [hdl/nvm_sec_pkg.sv]
package nvm_sec_pkg;
	// ==========================================================
	// Bus and register indices (byte address = 4 * index).
	localparam int unsigned AW = 18;
	localparam logic [15:0] IDX_KEY0 = 16'hff00;
	localparam logic [15:0] IDX_KEY3 = 16'hff06;
	localparam logic [15:0] IDX_OPT = 16'hff0f;
	localparam logic [15:0] IDX_ALIAS = 16'hbf0f;
	localparam logic [15:0] IDX_CFG = 16'h0100;
	localparam logic [15:0] IDX_SHADOW = 16'h0101;
	localparam logic [15:0] IDX_PAGE = 16'h0102;
	localparam logic [15:0] IDX_STATUS = 16'h0103;
	// ==========================================================
	// Flash word addresses and field layout.
	localparam logic [15:0] KEY_ADDR = 16'hff00;
	localparam logic [15:0] OPT_ADDR = 16'hff0e;
	localparam logic [5:0] PAGE_TOP = 6'h3f;
	localparam int unsigned BACKDOOR_ENABLE_BITS_HI = 7;
	localparam int unsigned BACKDOOR_ENABLE_BITS_LO = 6;
	localparam logic [1:0] BACKDOOR_ENABLE_BITS_ON = 2'h2;
	localparam logic [1:0] SEC_OPEN = 2'h2;
	localparam int unsigned KEY_WRITE_ACCESS_BIT_BIT = 5;
	localparam logic [15:0] KEY_BAD0 = 16'h0000;
	localparam logic [15:0] KEY_BAD1 = 16'hffff;
	localparam logic [2:0] KEY_WORDS = 3'h4;
	localparam logic [5:0] PAGE_RST = 6'h00;
	// ==========================================================
	// Operating modes and memory commands.
	localparam logic [1:0] MODE_SSC = 2'h0;
	localparam logic [1:0] MODE_SEX = 2'h1;
	localparam logic [1:0] MODE_NSC = 2'h2;
	localparam logic [1:0] MODE_NEX = 2'h3;
	localparam logic [7:0] CMD_VERIFY = 8'h05;
	localparam logic [7:0] CMD_PROGRAM_WORD_COMMAND = 8'h20;
	localparam logic [7:0] CMD_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;
	localparam logic [7:0] CMD_MODIFY = 8'h60;
	typedef enum logic [1:0] {
		ST_ADDR = 2'b00,
		ST_DATA = 2'b01,
		ST_RUN  = 2'b10
	} load_state_t;
endpackage

// [hdl/nvm_security_backdoor_unlock.sv]
`timescale 1ns/100ps
`default_nettype none
module nvm_security_backdoor_unlock
	import nvm_sec_pkg::*;
#(
	parameter bit SINGLE_BACKDOOR_ENABLE_BITS = 1'b0
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [AW-1:0] wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	input  wire logic          wb_dbg_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	output logic      [15:0]   flash_addr_o,
	input  wire logic [15:0]   flash_rdata_i,
	output logic               flash_read_block_o,
	input  wire logic [1:0]    mode_i,
	input  wire logic          cmd_valid_i,
	input  wire logic [7:0]    cmd_code_i,
	input  wire logic          cmd_from_ext_i,
	input  wire logic          cmd_option_sector_i,
	input  wire logic          cmd_sector_protected_i,
	output logic               cmd_accept_o,
	output logic               cmd_reject_o,
	output logic               secured_o,
	output logic               backdoor_enabled_o,
	output logic               debug_enable_o,
	output logic               debug_fw_enable_o,
	output logic               debug_hw_reg_only_o,
	output logic               ext_nvm_access_en_o,
	output logic               bus_visibility_output_o,
	output logic               cpu_pipe_status_output_o
);

	// ==========================================================
	// Decoders.
	function automatic logic keys_on(input logic [7:0] b);
		if (SINGLE_BACKDOOR_ENABLE_BITS)
			return b[BACKDOOR_ENABLE_BITS_HI];
		return b[BACKDOOR_ENABLE_BITS_HI:BACKDOOR_ENABLE_BITS_LO] == BACKDOOR_ENABLE_BITS_ON;
	endfunction

	function automatic logic program_word_command_erase(input logic [7:0] c);
		return c == CMD_PROGRAM_WORD_COMMAND || c == CMD_ERASE || c == CMD_MODIFY;
	endfunction

	function automatic logic known_cmd(input logic [7:0] c);
		return program_word_command_erase(c) || c == CMD_MASS || c == CMD_VERIFY;
	endfunction

	// ==========================================================
	// Reset load of the key and option words.
	load_state_t state_q, state_d;
	logic [2:0]  ld_idx_q, ld_idx_d;
	logic [15:0] key_q [4];
	logic [15:0] key_d [4];
	logic [7:0]  opt_q, opt_d;
	logic [7:0]  shadow_q, shadow_d;
	logic [1:0]  mode_s1_q, mode_s2_q, mode_q, mode_d;
	logic        unlocked_q, unlocked_d;
	logic        key_unlock;
	logic        run;

	assign run = state_q == ST_RUN;
	assign flash_addr_o = ld_idx_q == KEY_WORDS ? OPT_ADDR : KEY_ADDR + {12'h000, ld_idx_q, 1'b0};

	always_comb begin
		state_d = state_q;
		ld_idx_d = ld_idx_q;
		key_d = key_q;
		opt_d = opt_q;
		shadow_d = shadow_q;
		mode_d = mode_q;
		unlocked_d = unlocked_q;
		case (state_q)
			ST_ADDR: begin
				state_d = ST_DATA;
			end
			ST_DATA: begin
				if (ld_idx_q == KEY_WORDS) begin
					opt_d = flash_rdata_i[7:0];
					shadow_d = flash_rdata_i[7:0];
					mode_d = mode_s2_q;
					state_d = ST_RUN;
				end else begin
					key_d[ld_idx_q[1:0]] = flash_rdata_i;
					ld_idx_d = ld_idx_q + 3'h1;
					state_d = ST_ADDR;
				end
			end
			ST_RUN: begin
				// The stored byte is never rewritten here, so a
				// new flash value waits for the next reset.
				if (key_unlock) begin
					shadow_d[1:0] = SEC_OPEN;
					unlocked_d = 1'b1;
				end
			end
			default: begin
				state_d = ST_ADDR;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		mode_s1_q <= mode_i;
		mode_s2_q <= mode_s1_q;
		if (rst_i) begin
			state_q <= ST_ADDR;
			ld_idx_q <= 3'h0;
			opt_q <= 8'h00;
			shadow_q <= 8'h00;
			mode_q <= MODE_SSC;
			unlocked_q <= 1'b0;
			for (int i = 0; i < 4; i++)
				key_q[i] <= KEY_BAD1;
		end else begin
			state_q <= state_d;
			ld_idx_q <= ld_idx_d;
			opt_q <= opt_d;
			shadow_q <= shadow_d;
			mode_q <= mode_d;
			unlocked_q <= unlocked_d;
			key_q <= key_d;
		end
	end

	// ==========================================================
	// Security decode; treated as secured until the load ends.
	// Holding secured through the load keeps commands and firmware debug shut before
	// the stored byte is known, at the cost of refusing them for ten cycles.
	logic normal_mode;
	logic expanded;
	logic backdoor_ok;

	assign normal_mode = mode_q == MODE_NSC || mode_q == MODE_NEX;
	assign expanded = mode_q == MODE_NEX || mode_q == MODE_SEX;
	assign secured_o = !run || shadow_q[1:0] != SEC_OPEN;
	assign backdoor_ok = run && normal_mode && keys_on(opt_q);
	assign backdoor_enabled_o = backdoor_ok;
	assign debug_enable_o = !(secured_o && (mode_q == MODE_NSC || expanded));
	assign debug_fw_enable_o = debug_enable_o && !(secured_o && mode_q == MODE_SSC);
	assign debug_hw_reg_only_o = secured_o && mode_q == MODE_SSC;
	assign ext_nvm_access_en_o = !(secured_o && expanded);
	assign bus_visibility_output_o = !(secured_o && expanded);
	assign cpu_pipe_status_output_o = !(secured_o && expanded);

	// ==========================================================
	// Memory command gate.
	always_comb begin
		cmd_accept_o = cmd_valid_i && run && known_cmd(cmd_code_i);
		if (cmd_option_sector_i && cmd_sector_protected_i && program_word_command_erase(cmd_code_i))
			cmd_accept_o = 1'b0;
		if (secured_o && mode_q == MODE_SSC && cmd_code_i != CMD_MASS)
			cmd_accept_o = 1'b0;
		if (secured_o && mode_q == MODE_NEX && cmd_from_ext_i)
			cmd_accept_o = 1'b0;
		cmd_reject_o = cmd_valid_i && !cmd_accept_o;
	end

	// ==========================================================
	// Wishbone slave and backdoor key checker.
	logic        ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic        key_write_access_bit_q, key_write_access_bit_d;
	logic [5:0]  page_q, page_d;
	logic [2:0]  key_cnt_q, key_cnt_d;
	logic [3:0]  match_q, match_d;
	logic        bad_q, bad_d;
	logic        req;
	logic        wr_fire;
	logic [15:0] idx;
	logic        key_hit;
	logic [1:0]  slot;

	assign idx = wb_adr_i[AW-1:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_q && run;
	// A write lands on the edge where the master sees ack.
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	assign key_hit = idx >= IDX_KEY0 && idx <= IDX_KEY3 && !idx[0];
	assign slot = idx[2:1];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign flash_read_block_o = key_write_access_bit_q;

	always_comb begin
		ack_d = req;
		dat_d = 32'h0000_0000;
		key_write_access_bit_d = key_write_access_bit_q;
		page_d = page_q;
		key_cnt_d = key_cnt_q;
		match_d = match_q;
		bad_d = bad_q;
		key_unlock = 1'b0;
		if (req && !wb_we_i) begin
			case (idx)
				IDX_OPT: dat_d[7:0] = key_write_access_bit_q ? 8'h00 : opt_q;
				IDX_ALIAS: dat_d[7:0] = (key_write_access_bit_q || page_q != PAGE_TOP) ? 8'h00 : opt_q;
				IDX_CFG: dat_d[KEY_WRITE_ACCESS_BIT_BIT] = key_write_access_bit_q;
				IDX_SHADOW: dat_d[7:0] = shadow_q;
				IDX_PAGE: dat_d[5:0] = page_q;
				IDX_STATUS: dat_d[12:0] = {mode_q, unlocked_q, backdoor_ok, secured_o, key_cnt_q, match_q, bad_q};
				default: dat_d = 32'h0000_0000;
			endcase
		end
		if (wr_fire && idx == IDX_PAGE && wb_sel_i[0])
			page_d = wb_dat_i[5:0];
		// Debug-port key words are dropped silently.
		// An out-of-order word poisons the attempt; a retry must set the access bit again.
		if (wr_fire && key_hit && key_write_access_bit_q && !wb_dbg_i && wb_sel_i[1:0] == 2'h3) begin
			if (key_cnt_q < KEY_WORDS && slot == key_cnt_q[1:0]) begin
				match_d[slot] = wb_dat_i[15:0] == key_q[slot] && key_q[slot] != KEY_BAD0
					&& key_q[slot] != KEY_BAD1;
				key_cnt_d = key_cnt_q + 3'h1;
			end else begin
				bad_d = 1'b1;
			end
		end
		if (wr_fire && idx == IDX_CFG && wb_sel_i[0]) begin
			key_write_access_bit_d = wb_dat_i[KEY_WRITE_ACCESS_BIT_BIT];
			if (!key_write_access_bit_q && key_write_access_bit_d) begin
				key_cnt_d = 3'h0;
				match_d = 4'h0;
				bad_d = 1'b0;
			end
			if (key_write_access_bit_q && !key_write_access_bit_d)
				key_unlock = key_cnt_q == KEY_WORDS && &match_q && !bad_q && backdoor_ok;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			key_write_access_bit_q <= 1'b0;
			page_q <= PAGE_RST;
			key_cnt_q <= 3'h0;
			match_q <= 4'h0;
			bad_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			key_write_access_bit_q <= key_write_access_bit_d;
			page_q <= page_d;
			key_cnt_q <= key_cnt_d;
			match_q <= match_d;
			bad_q <= bad_d;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_shadow_load: assert property (state_q == ST_DATA && ld_idx_q == KEY_WORDS
		|=> shadow_q == $past(flash_rdata_i[7:0]) && run)
		else $error("shadow not loaded from option word");
	chk_alias_read: assert property (req && !wb_we_i && idx == IDX_ALIAS
		&& page_q == PAGE_TOP && !key_write_access_bit_q |=> wb_ack_o && wb_dat_o[7:0] == opt_q)
		else $error("alias read wrong");
	chk_option_prot: assert property (cmd_valid_i && cmd_option_sector_i
		&& cmd_sector_protected_i && program_word_command_erase(cmd_code_i) |-> cmd_reject_o)
		else $error("protected option sector changed");
	chk_key_enable: assert property (run && !SINGLE_BACKDOOR_ENABLE_BITS
		&& opt_q[BACKDOOR_ENABLE_BITS_HI:BACKDOOR_ENABLE_BITS_LO] != BACKDOOR_ENABLE_BITS_ON |-> !backdoor_enabled_o)
		else $error("backdoor enabled by wrong pair");
	chk_secure_hold: assert property (run && !key_unlock
		|=> shadow_q == $past(shadow_q) && secured_o == $past(secured_o))
		else $error("security changed without reset");
	chk_nsc_debug: assert property (secured_o && run && mode_q == MODE_NSC
		|-> !debug_enable_o && (!(cmd_valid_i && cmd_code_i == CMD_MASS) || cmd_accept_o))
		else $error("normal single chip gating wrong");
	chk_ssc_cmds: assert property (secured_o && mode_q == MODE_SSC && cmd_valid_i
		&& cmd_code_i != CMD_MASS |-> !cmd_accept_o)
		else $error("special single chip command allowed");
	chk_expanded: assert property (secured_o && expanded |-> !debug_enable_o
		&& !ext_nvm_access_en_o && !bus_visibility_output_o && !cpu_pipe_status_output_o)
		else $error("expanded gating wrong");
	chk_ext_fetch: assert property (secured_o && mode_q == MODE_NEX && cmd_from_ext_i
		|-> !cmd_accept_o)
		else $error("external fetched command allowed");
	chk_read_block: assert property (req && !wb_we_i && idx == IDX_OPT && key_write_access_bit_q
		|=> wb_dat_o == 32'h0000_0000)
		else $error("flash data returned under key access");
	chk_unlock_sec: assert property (key_unlock |=> !secured_o
		&& shadow_q[1:0] == SEC_OPEN && opt_q == $past(opt_q))
		else $error("unlock did not open security");
	chk_debug_key: assert property (wr_fire && wb_dbg_i && key_hit
		|=> key_cnt_q == $past(key_cnt_q) && match_q == $past(match_q))
		else $error("debug key write accepted");
	chk_mismatch: assert property (key_write_access_bit_q && wr_fire && idx == IDX_CFG
		&& !wb_dat_i[KEY_WRITE_ACCESS_BIT_BIT] && !(&match_q) && wb_sel_i[0] |=> secured_o == $past(secured_o))
		else $error("mismatch unsecured device");

	// ==========================================================
	// Decode and key checks.
	// These hold the outputs against the stored fields bit by bit, so a
	// decode slip shows even in modes that no test selects.
	chk_sec_open: assert property (run && shadow_q[1] && !shadow_q[0]
		|-> !secured_o)
		else $error("open security pair left device secured");
	chk_sec_closed: assert property (run && !(shadow_q[1] && !shadow_q[0])
		|-> secured_o)
		else $error("closed security pair left device open");
	chk_key_pair_on: assert property (run && normal_mode && !SINGLE_BACKDOOR_ENABLE_BITS
		&& opt_q[BACKDOOR_ENABLE_BITS_HI] && !opt_q[BACKDOOR_ENABLE_BITS_LO] |-> backdoor_enabled_o)
		else $error("enable pair did not enable backdoor");
	chk_key_single: assert property (run && normal_mode && SINGLE_BACKDOOR_ENABLE_BITS
		|-> backdoor_enabled_o == opt_q[BACKDOOR_ENABLE_BITS_HI])
		else $error("single enable bit decoded wrong");
	chk_mode_key: assert property (run && !normal_mode
		|-> !backdoor_enabled_o && !key_unlock)
		else $error("backdoor usable in special mode");
	chk_ssc_debug: assert property (secured_o && mode_q == MODE_SSC
		|-> !debug_fw_enable_o && debug_hw_reg_only_o)
		else $error("special single chip debug gating wrong");
	chk_opt_stable: assert property (run
		|=> opt_q == $past(opt_q))
		else $error("stored option byte changed before reset");
	chk_shadow_spare: assert property (run
		|-> shadow_q[7:2] == opt_q[7:2])
		else $error("shadow upper bits differ from stored byte");
	chk_word_compare: assert property (wr_fire && key_hit && key_write_access_bit_q && !wb_dbg_i
		&& wb_sel_i[1:0] == 2'h3 && key_cnt_q < KEY_WORDS && slot == key_cnt_q[1:0]
		&& wb_dat_i[15:0] != key_q[slot] |=> !match_q[$past(slot)])
		else $error("wrong key word counted as match");
	chk_load_refuse: assert property (!run
		|-> !cmd_accept_o && secured_o)
		else $error("command or access open during load");
	chk_nsc_cmds: assert property (secured_o && run && mode_q == MODE_NSC && cmd_valid_i
		&& known_cmd(cmd_code_i) && !cmd_sector_protected_i |-> cmd_accept_o)
		else $error("normal single chip command refused");
	chk_open_gates: assert property (run && !secured_o
		|-> debug_enable_o && ext_nvm_access_en_o && bus_visibility_output_o && cpu_pipe_status_output_o)
		else $error("unsecured device still gated");
	chk_alias_page: assert property (req && !wb_we_i && idx == IDX_ALIAS && page_q != PAGE_TOP
		|=> wb_dat_o == 32'h0000_0000)
		else $error("alias read outside top page");
	chk_alias_block: assert property (req && !wb_we_i && idx == IDX_ALIAS && key_write_access_bit_q
		|=> wb_dat_o == 32'h0000_0000)
		else $error("alias data returned under key access");

endmodule
`default_nettype wire

// [dv/flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
	parameter logic [15:0] KEY_W0 = 16'h1234,
	parameter logic [15:0] KEY_W1 = 16'h5678,
	parameter logic [15:0] KEY_W2 = 16'h9abc,
	parameter logic [15:0] KEY_W3 = 16'hdef1
) (
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  opt_i,
	output logic      [15:0] rdata_o
);
	// ==========================================================
	// Array read port.
	// Data follows the address by one cycle; unprogrammed words read as erased.
	always_ff @(posedge clk_i) begin
		case (addr_i)
			16'hff00: rdata_o <= KEY_W0;
			16'hff02: rdata_o <= KEY_W1;
			16'hff04: rdata_o <= KEY_W2;
			16'hff06: rdata_o <= KEY_W3;
			16'hff0e: rdata_o <= {8'hff, opt_i};
			default:  rdata_o <= 16'hffff;
		endcase
	end
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import nvm_sec_pkg::*;
	localparam logic [15:0] KEYS [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef1};
	localparam logic [7:0] CODES [5] = '{CMD_PROGRAM_WORD_COMMAND, CMD_MASS, CMD_ERASE, CMD_VERIFY, CMD_MODIFY};
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, dbg = 0;
	logic [AW-1:0] adr = '0;
	logic [31:0] wdat = '0, rdat;
	logic ack, fblk, acc, rej, sec, bden, dben, dbfw, dbreg, extn, vis, pipe;
	logic [15:0] faddr, frdata;
	logic [1:0] mode = MODE_NSC;
	logic [7:0] opt = 8'h83, ccode = 8'h00;
	logic cval = 0, cext = 0, cosec = 0, cprot = 0;
	int miscompares = 0;
	int total_checks = 0;
	always #2 clk_i = ~clk_i;
	nvm_security_backdoor_unlock u_nvm_security_backdoor_unlock (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dbg_i(dbg), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(faddr),
		.flash_rdata_i(frdata), .flash_read_block_o(fblk), .mode_i(mode), .cmd_valid_i(cval),
		.cmd_code_i(ccode), .cmd_from_ext_i(cext), .cmd_option_sector_i(cosec),
		.cmd_sector_protected_i(cprot), .cmd_accept_o(acc), .cmd_reject_o(rej), .secured_o(sec),
		.backdoor_enabled_o(bden), .debug_enable_o(dben), .debug_fw_enable_o(dbfw),
		.debug_hw_reg_only_o(dbreg), .ext_nvm_access_en_o(extn), .bus_visibility_output_o(vis),
		.cpu_pipe_status_output_o(pipe));
	flash_model #(.KEY_W0(KEYS[0]), .KEY_W1(KEYS[1]), .KEY_W2(KEYS[2]), .KEY_W3(KEYS[3])) u_flash_model (
		.clk_i(clk_i), .addr_i(faddr), .opt_i(opt), .rdata_o(frdata));
	// ==========================================================
	// Checking and bus helpers.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// The request is held until ack is seen, so slow answers after reset are safe.
	task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic g,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		dbg <= g;
		adr <= {idx, 2'b00};
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic g);
		logic [31:0] q;
		bus(1'b1, idx, d, g, q);
	endtask
	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, 1'b0, q);
		chk(q, exp, "read");
	endtask
	task automatic do_reset(input logic [7:0] o, input logic [1:0] m);
		@(posedge clk_i);
		opt <= o;
		mode <= m;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic key_seq(input int bad, input logic g);
		wr(IDX_CFG, 32'h20, 1'b0);
		for (int i = 0; i < 4; i++) wr(IDX_KEY0 + 16'(2 * i), {16'h0, KEYS[i] ^ 16'(i == bad)}, g);
		wr(IDX_CFG, 32'h0, 1'b0);
		@(posedge clk_i);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c, input logic e, input logic os, input logic pr, input logic exp);
		@(posedge clk_i);
		cval <= 1'b1;
		ccode <= c;
		cext <= e;
		cosec <= os;
		cprot <= pr;
		#1 chk({acc, rej}, {exp, !exp}, "cmd");
	endtask
	// ==========================================================
	// Scenarios.
	task automatic test_secured_normal();
		do_reset(8'h83, MODE_NSC);
		rdchk(IDX_OPT, 32'h83);
		rdchk(IDX_SHADOW, 32'h83);
		rdchk(16'h0200, 32'h0);
		chk({sec, bden, dben}, 3'b110, "flags");
		foreach (CODES[i]) cmd(CODES[i], 1'b0, 1'b0, 1'b0, 1'b1);
		key_seq(2, 1'b0);
		chk(sec, 1'b1, "bad key");
		key_seq(4, 1'b1);
		chk(sec, 1'b1, "debug key");
		wr(IDX_CFG, 32'h20, 1'b0);
		#1 chk(fblk, 1'b1, "block");
		rdchk(IDX_OPT, 32'h0);
		key_seq(4, 1'b0);
		chk({sec, dben}, 2'b01, "good key");
		rdchk(IDX_SHADOW, 32'h82);
		rdchk(IDX_OPT, 32'h83);
		do_reset(8'h83, MODE_NSC);
		rdchk(IDX_SHADOW, 32'h83);
		chk(sec, 1'b1, "relock");
		$display("test secured normal done");
	endtask
	task automatic test_special();
		do_reset(8'h83, MODE_SSC);
		rdchk(IDX_OPT, 32'h83);
		chk({dbfw, dbreg}, 2'b01, "special debug");
		foreach (CODES[i]) cmd(CODES[i], 1'b0, 1'b0, 1'b0, CODES[i] == CMD_MASS);
		key_seq(4, 1'b0);
		chk(sec, 1'b1, "special key");
		$display("test special done");
	endtask
	task automatic test_expanded();
		do_reset(8'h83, MODE_NEX);
		rdchk(IDX_OPT, 32'h83);
		chk({dben, extn, vis, pipe}, 4'h0, "expanded");
		cmd(CMD_PROGRAM_WORD_COMMAND, 1'b1, 1'b0, 1'b0, 1'b0);
		cmd(CMD_PROGRAM_WORD_COMMAND, 1'b0, 1'b0, 1'b0, 1'b1);
		key_seq(4, 1'b0);
		chk({sec, extn}, 2'b01, "expanded key");
		$display("test expanded done");
	endtask
	task automatic test_open();
		do_reset(8'h42, MODE_NSC);
		rdchk(IDX_OPT, 32'h42);
		chk({sec, bden}, 2'b00, "open");
		wr(IDX_PAGE, {26'h0, PAGE_TOP}, 1'b0);
		rdchk(IDX_ALIAS, 32'h42);
		cmd(CMD_PROGRAM_WORD_COMMAND, 1'b0, 1'b1, 1'b1, 1'b0);
		cmd(CMD_PROGRAM_WORD_COMMAND, 1'b0, 1'b1, 1'b0, 1'b1);
		$display("test open done");
	endtask
	initial begin
		#20000;
		miscompares++;
		$display("mismatch %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		test_secured_normal();
		test_special();
		test_expanded();
		test_open();
		stop_test();
	end
endmodule
`default_nettype wire
